//--- verilog/sbc_pkg.sv
// Purpose: Shared constants and types for the mode sequencer and its host.
// Assumes: pclk at 10 MHz on both ends.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`default_nettype none
package sbc_pkg;
	// ==========================================================
	// Clock and times
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned NREQ_TIMEOUT_MS = 350;
	localparam int unsigned RESET_HOLD_MS = 15;
	localparam int unsigned WD_UNIT_MS = 10;
	localparam int unsigned INT_PULSE_US = 10;
	localparam int unsigned DEGLITCH_US = 40;
	localparam int unsigned FIRST_SPI_US = 50;
	localparam int unsigned NREQ_TIMEOUT_DEF = NREQ_TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned RESET_HOLD_DEF = RESET_HOLD_MS * CYC_PER_MS;
	localparam int unsigned WD_UNIT_DEF = WD_UNIT_MS * CYC_PER_MS;
	localparam logic [31:0] INT_PULSE_CYC = 32'(INT_PULSE_US * CYC_PER_US);
	localparam logic [31:0] DEGLITCH_CYC = 32'(DEGLITCH_US * CYC_PER_US);
	localparam logic [31:0] FIRST_SPI_CYC = 32'(FIRST_SPI_US * CYC_PER_US);
	// Link clock made by the host: 800 ns period, half of it in pclk cycles.
	localparam int unsigned LINK_PERIOD_NS = 800;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam logic [3:0] SCK_HALF_CYC =
		4'(LINK_PERIOD_NS / CLK_PERIOD_NS / 2);
	localparam logic [3:0] FRAME_GAP_CYC = 4'h8;
	// ==========================================================
	// Frame layout: command nibble, then data nibble.
	localparam logic [3:0] FRAME_BITS = 4'h8;
	localparam logic [3:0] CMD_STATUS = 4'h0;
	localparam logic [3:0] CMD_TIMING = 4'h1;
	localparam logic [3:0] CMD_MODE = 4'h2;
	localparam logic [3:0] CMD_HS = 4'h3;
	localparam logic [3:0] CMD_CLEAR = 4'h4;
	localparam logic [2:0] REQ_NORMAL = 3'h1;
	localparam logic [2:0] REQ_STANDBY = 3'h2;
	localparam logic [2:0] REQ_STOP = 3'h3;
	localparam logic [2:0] REQ_SLEEP = 3'h4;
	localparam int unsigned STOP_WD_BIT = 3;
	// Watchdog period multipliers of WD_UNIT for timing data 0..3.
	localparam logic [5:0] WD_MULT0 = 6'h01;
	localparam logic [5:0] WD_MULT1 = 6'h05;
	localparam logic [5:0] WD_MULT2 = 6'h0A;
	localparam logic [5:0] WD_MULT3 = 6'h23;
	// Synchroniser reset: chip select idles high (bit 9).
	localparam logic [10:0] SYNC_RST = 11'h200;
	// ==========================================================
	// Host register map
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_STAT = 12'h004;
	localparam logic [11:0] REG_RX = 12'h008;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_INT = 1;
	localparam int unsigned STAT_RST = 2;
	localparam int unsigned STAT_WDF = 3;
	// ==========================================================
	typedef enum logic [2:0] {
		M_RESET, M_NREQ, M_NORMAL, M_STANDBY, M_STOP, M_SLEEP
	} mode_t;
	typedef enum logic [2:0] {
		H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP
	} host_st_t;
endpackage
`default_nettype wire

//--- verilog/sbc_link_if.sv
// Purpose: Pins between the mode sequencer and the host controller.
// Assumes: Both ends run on their own pclk; all pins are plain levels.
// Notes: Serial clock is made by the host.
`default_nettype none
interface sbc_link_if;
	logic spi_sck;
	logic spi_cs_n;
	logic spi_mosi;
	logic spi_miso;
	logic int_n;
	logic rst_n;
	logic watchdog_fault_out;
	modport dev (input spi_sck, input spi_cs_n, input spi_mosi,
		output spi_miso, output int_n, output rst_n,
		output watchdog_fault_out);
	modport host (output spi_sck, output spi_cs_n, output spi_mosi,
		input spi_miso, input int_n, input rst_n,
		input watchdog_fault_out);
endinterface
`default_nettype wire

//--- verilog/sbc_dev.sv
// Purpose: Operating-mode sequencer with wake handling and serial port.
// Assumes: Link pins and wake sources are asynchronous to pclk.
// Notes: Long counts are parameters so a bench can shorten them.
`default_nettype none
module sbc_dev #(
	parameter int unsigned NREQ_TIMEOUT_CYC = sbc_pkg::NREQ_TIMEOUT_DEF,
	parameter int unsigned RESET_HOLD_CYC = sbc_pkg::RESET_HOLD_DEF,
	parameter int unsigned WD_UNIT_CYC = sbc_pkg::WD_UNIT_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	sbc_link_if.dev link,
	input wire logic can_wake_evt,
	input wire logic [3:0] wake_inputs,
	input wire logic idd_over,
	input wire logic vdd_low,
	input wire logic forced_wake,
	output logic aux_regulator_on,
	output logic high_side_switch_on,
	output logic [2:0] mode_out
);
	import sbc_pkg::*;

	// ==========================================================
	// Input synchronisers and edge finders
	logic [10:0] in_raw, sync1_ff, sync2_ff, prev_ff;
	logic s_sck, s_cs, s_idd, s_vdd;
	logic sck_rise, sck_fall, cs_rise, cs_fall;
	logic can_evt, fwu_evt, wake_chg;

	assign in_raw = {link.spi_sck, link.spi_cs_n, link.spi_mosi,
		can_wake_evt, forced_wake, idd_over, vdd_low, wake_inputs};

	// Edges are taken from the second stage only, never the first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
			prev_ff <= SYNC_RST;
		end else begin
			sync1_ff <= in_raw;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign s_sck = sync2_ff[10];
	assign s_cs = sync2_ff[9];
	assign s_idd = sync2_ff[5];
	assign s_vdd = sync2_ff[4];
	assign sck_rise = s_sck & ~prev_ff[10];
	assign sck_fall = ~s_sck & prev_ff[10];
	assign cs_rise = s_cs & ~prev_ff[9];
	assign cs_fall = ~s_cs & prev_ff[9];
	assign can_evt = sync2_ff[7] & ~prev_ff[7];
	assign fwu_evt = sync2_ff[6] & ~prev_ff[6];
	assign wake_chg = |(sync2_ff[3:0] ^ prev_ff[3:0]);

	// ==========================================================
	// Serial port: sample on rising, shift out on falling.
	mode_t mode_ff, nxt_mode;
	logic [3:0] bitcnt_ff;
	logic [7:0] rx_ff, tx_ff, status_byte;
	logic miso_ff, spi_open, frame_ok;
	logic [3:0] f_cmd, f_data;
	logic [31:0] gap_ff;
	logic can_wake_flag_ff;
	logic [3:0] wake_input_flag_ff;

	assign status_byte = {can_wake_flag_ff, wake_input_flag_ff, mode_ff};
	assign f_cmd = rx_ff[7:4];
	assign f_data = rx_ff[3:0];
	// Frames are ignored in reset, sleep and the first-command delay.
	assign spi_open = (gap_ff == '0) && (mode_ff != M_RESET) &&
		(mode_ff != M_SLEEP);
	assign frame_ok = cs_rise && (bitcnt_ff == FRAME_BITS) && spi_open;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitcnt_ff <= '0;
			rx_ff <= '0;
			tx_ff <= '0;
			miso_ff <= 1'b0;
		end else if (cs_fall) begin
			bitcnt_ff <= '0;
			tx_ff <= status_byte;
			miso_ff <= status_byte[7];
		end else if (!s_cs && sck_rise) begin
			rx_ff <= {rx_ff[6:0], sync2_ff[8]};
			bitcnt_ff <= bitcnt_ff + 4'h1;
		end else if (!s_cs && sck_fall) begin
			tx_ff <= {tx_ff[6:0], 1'b0};
			miso_ff <= tx_ff[6];
		end
	end

	// ==========================================================
	// Command decode
	logic tm_frame, mode_frame, hs_frame, clr_frame;
	logic req_run, req_stop, req_sleep;
	mode_t req_mode;

	assign tm_frame = frame_ok && (f_cmd == CMD_TIMING);
	assign mode_frame = frame_ok && (f_cmd == CMD_MODE);
	assign hs_frame = frame_ok && (f_cmd == CMD_HS);
	assign clr_frame = frame_ok && (f_cmd == CMD_CLEAR);
	assign req_run = mode_frame && ((f_data[2:0] == REQ_NORMAL) ||
		(f_data[2:0] == REQ_STANDBY));
	assign req_stop = mode_frame && (f_data[2:0] == REQ_STOP);
	assign req_sleep = mode_frame && (f_data[2:0] == REQ_SLEEP);
	assign req_mode = (f_data[2:0] == REQ_NORMAL) ? M_NORMAL : M_STANDBY;

	// ==========================================================
	// Watchdog
	logic [1:0] wd_sel_ff;
	logic [31:0] wd_cnt_ff, wd_load;
	logic wd_cfg_ff, stop_wd_en_ff, wd_run, wd_exp;

	function automatic logic [31:0] wd_period(input logic [1:0] sel);
		logic [5:0] mult;
		unique case (sel)
			2'h0: mult = WD_MULT0;
			2'h1: mult = WD_MULT1;
			2'h2: mult = WD_MULT2;
			2'h3: mult = WD_MULT3;
		endcase
		return 32'(WD_UNIT_CYC) * {26'h0, mult};
	endfunction

	// The watchdog stands still in sleep and request mode.
	assign wd_run = (mode_ff == M_NORMAL) || (mode_ff == M_STANDBY) ||
		(mode_ff == M_STOP && stop_wd_en_ff);
	assign wd_exp = wd_run && (wd_cnt_ff == '0);
	assign wd_load = wd_period(tm_frame ? f_data[1:0] : wd_sel_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_cnt_ff <= '0;
			wd_sel_ff <= '0;
			stop_wd_en_ff <= 1'b0;
		end else begin
			wd_cnt_ff <= (tm_frame || !wd_run) ? wd_load :
				wd_cnt_ff - 32'h1;
			if (tm_frame)
				wd_sel_ff <= f_data[1:0];
			if (req_stop)
				stop_wd_en_ff <= f_data[STOP_WD_BIT];
		end
	end

	// ==========================================================
	// Mode sequencer
	logic [31:0] timer_ff, nxt_timer;
	logic from_sleep_ff, nxt_from_sleep, int_start, int_pend_ff;
	logic stop_wake, sleep_wake, oc_wake;

	// Over-current only counts once the deglitch time after entry is over.
	assign oc_wake = s_idd && (timer_ff == '0);
	assign stop_wake = cs_rise || can_evt || wake_chg || fwu_evt ||
		oc_wake;
	assign sleep_wake = cs_rise || can_evt || wake_chg || fwu_evt;

	always_comb begin
		nxt_mode = mode_ff;
		nxt_timer = (timer_ff != '0) ? timer_ff - 32'h1 : '0;
		nxt_from_sleep = from_sleep_ff;
		int_start = 1'b0;
		unique case (mode_ff)
			M_RESET: begin
				if (timer_ff == '0) begin
					nxt_mode = M_NREQ;
					nxt_timer = 32'(NREQ_TIMEOUT_CYC - 1);
				end
			end
			M_NREQ: begin
				if (req_run && wd_cfg_ff) begin
					nxt_mode = req_mode;
				end else if (!wd_cfg_ff && timer_ff == '0) begin
					if (from_sleep_ff) begin
						nxt_mode = M_SLEEP;
					end else begin
						nxt_mode = M_RESET;
						nxt_timer = 32'(RESET_HOLD_CYC - 1);
					end
				end
			end
			M_NORMAL, M_STANDBY: begin
				if (wd_exp) begin
					nxt_mode = M_RESET;
					nxt_timer = 32'(RESET_HOLD_CYC - 1);
				end else if (req_run) begin
					nxt_mode = req_mode;
				end else if (req_stop) begin
					nxt_mode = M_STOP;
					nxt_timer = DEGLITCH_CYC - 32'h1;
				end else if (req_sleep) begin
					nxt_mode = M_SLEEP;
				end
			end
			M_STOP: begin
				if (stop_wake) begin
					nxt_mode = M_NREQ;
					nxt_timer = 32'(NREQ_TIMEOUT_CYC - 1);
					nxt_from_sleep = 1'b0;
					int_start = 1'b1;
				end else if (wd_exp) begin
					nxt_mode = M_RESET;
					nxt_timer = 32'(RESET_HOLD_CYC - 1);
					nxt_from_sleep = 1'b0;
				end
			end
			M_SLEEP: begin
				if (sleep_wake) begin
					nxt_mode = M_RESET;
					nxt_timer = 32'(RESET_HOLD_CYC - 1);
					nxt_from_sleep = 1'b1;
				end
			end
			default: begin
				nxt_mode = M_RESET;
				nxt_timer = 32'(RESET_HOLD_CYC - 1);
			end
		endcase
		// Low supply wins over everything except sleep, where it is off.
		if (s_vdd && mode_ff != M_SLEEP) begin
			nxt_mode = M_RESET;
			nxt_timer = 32'(RESET_HOLD_CYC - 1);
			nxt_from_sleep = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= M_RESET;
			timer_ff <= 32'(RESET_HOLD_CYC - 1);
			from_sleep_ff <= 1'b0;
			int_pend_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			timer_ff <= nxt_timer;
			from_sleep_ff <= nxt_from_sleep;
			int_pend_ff <= int_start;
		end
	end

	// ==========================================================
	// Configuration, flags and pins
	logic [31:0] int_cnt_ff, nxt_int_cnt;
	logic int_n_ff, rst_n_ff, wdf_ff, aux_ff, hs_ff, hs_req_ff;
	logic wd_cfg_clr;
	logic [3:0] nxt_wake_flag;
	logic nxt_can_flag;

	// Pulse starts the cycle after request mode is already entered.
	assign nxt_int_cnt = int_pend_ff ? INT_PULSE_CYC :
		(int_cnt_ff != '0) ? int_cnt_ff - 32'h1 : '0;
	assign wd_cfg_clr = (nxt_mode == M_NREQ) && (mode_ff != M_NREQ);
	// Over-current and forced wakes set nothing; set beats clear.
	assign nxt_can_flag = (can_wake_flag_ff & ~clr_frame) |
		(can_evt && (mode_ff == M_STOP || mode_ff == M_SLEEP));
	assign nxt_wake_flag = (wake_input_flag_ff & {4{~clr_frame}}) |
		((sync2_ff[3:0] ^ prev_ff[3:0]) &
		{4{mode_ff == M_STOP || mode_ff == M_SLEEP}});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_cnt_ff <= '0;
			gap_ff <= '0;
			wd_cfg_ff <= 1'b0;
			can_wake_flag_ff <= 1'b0;
			wake_input_flag_ff <= '0;
			hs_req_ff <= 1'b0;
			int_n_ff <= 1'b1;
			rst_n_ff <= 1'b0;
			wdf_ff <= 1'b0;
			aux_ff <= 1'b0;
			hs_ff <= 1'b0;
			mode_out <= '0;
		end else begin
			int_cnt_ff <= nxt_int_cnt;
			gap_ff <= (int_cnt_ff != '0) ? FIRST_SPI_CYC :
				(gap_ff != '0) ? gap_ff - 32'h1 : '0;
			wd_cfg_ff <= wd_cfg_clr ? 1'b0 : (wd_cfg_ff | tm_frame);
			can_wake_flag_ff <= nxt_can_flag;
			wake_input_flag_ff <= nxt_wake_flag;
			if (hs_frame)
				hs_req_ff <= f_data[0];
			int_n_ff <= (nxt_int_cnt == '0);
			rst_n_ff <= (nxt_mode != M_RESET) &&
				(nxt_mode != M_SLEEP);
			wdf_ff <= (wd_exp && nxt_mode == M_RESET) ||
				(wdf_ff && !tm_frame);
			aux_ff <= (nxt_mode == M_NORMAL);
			hs_ff <= hs_req_ff && ((nxt_mode == M_NORMAL) ||
				(nxt_mode == M_STANDBY));
			mode_out <= nxt_mode;
		end
	end

	assign link.spi_miso = miso_ff;
	assign link.int_n = int_n_ff;
	assign link.rst_n = rst_n_ff;
	assign link.watchdog_fault_out = wdf_ff;
	assign aux_regulator_on = aux_ff;
	assign high_side_switch_on = hs_ff;
endmodule // sbc_dev
`default_nettype wire

//--- verilog/sbc_host.sv
// Purpose: Host controller: APB registers drive serial frames to the device.
// Assumes: Device pins are asynchronous to this pclk.
// Notes: Serial clock is divided from pclk and driven out.
`default_nettype none
module sbc_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	sbc_link_if.host link
);
	import sbc_pkg::*;

	// ==========================================================
	// Synchronisers for device pins
	logic [3:0] in_raw, sync1_ff, sync2_ff, prev_ff;
	logic s_miso, s_int_n, s_rst_n, s_wdf, int_fall;

	assign in_raw = {link.spi_miso, link.int_n, link.rst_n,
		link.watchdog_fault_out};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 4'h4;
			sync2_ff <= 4'h4;
			prev_ff <= 4'h4;
		end else begin
			sync1_ff <= in_raw;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign s_miso = sync2_ff[3];
	assign s_int_n = sync2_ff[2];
	assign s_rst_n = sync2_ff[1];
	assign s_wdf = sync2_ff[0];
	assign int_fall = ~s_int_n & prev_ff[2];

	// ==========================================================
	// APB decode; one wait-free access with a registered answer.
	logic setup, wr_cmd, wr_stat, hit, busy, start;
	logic [31:0] rd_mux;
	logic [7:0] tx_ff, rx_ff;
	logic int_seen_ff;
	logic [31:0] hold_ff;
	host_st_t st_ff;

	assign setup = psel && !penable;
	assign hit = (paddr == REG_CMD) || (paddr == REG_STAT) ||
		(paddr == REG_RX);
	assign wr_cmd = psel && penable && pready && pwrite && paddr == REG_CMD;
	assign wr_stat = psel && penable && pready && pwrite &&
		paddr == REG_STAT;
	assign busy = (st_ff != H_IDLE) || (hold_ff != '0);
	// A command written while busy or in the post-pulse delay is dropped.
	assign start = wr_cmd && !busy;
	// Status shows reset and fault so software can service in time.
	assign rd_mux = (paddr == REG_STAT) ? {28'h0, s_wdf, s_rst_n,
		int_seen_ff, busy} : (paddr == REG_RX) ? {24'h0, rx_ff} :
		'0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
			int_seen_ff <= 1'b0;
			hold_ff <= '0;
		end else begin
			pready <= setup;
			prdata <= rd_mux;
			pslverr <= setup && !hit;
			int_seen_ff <= int_fall ||
				(int_seen_ff && !(wr_stat && pwdata[STAT_INT]));
			hold_ff <= !s_int_n ? FIRST_SPI_CYC :
				(hold_ff != '0) ? hold_ff - 32'h1 : '0;
		end
	end

	// ==========================================================
	// Frame engine: mosi changes on falling, miso sampled before it.
	logic [3:0] ph_ff, bit_ff;
	logic sck_ff, cs_n_ff, mosi_ff, ph_done;

	assign ph_done = (ph_ff == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= H_IDLE;
			ph_ff <= '0;
			bit_ff <= '0;
			tx_ff <= '0;
			rx_ff <= '0;
			sck_ff <= 1'b0;
			cs_n_ff <= 1'b1;
			mosi_ff <= 1'b0;
		end else begin
			ph_ff <= ph_done ? SCK_HALF_CYC - 4'h1 : ph_ff - 4'h1;
			unique case (st_ff)
				H_IDLE: begin
					if (start) begin
						// Any frame's closing edge also wakes a stopped device.
						st_ff <= H_LEAD;
						tx_ff <= pwdata[7:0];
						mosi_ff <= pwdata[7];
						cs_n_ff <= 1'b0;
						bit_ff <= '0;
						ph_ff <= SCK_HALF_CYC - 4'h1;
					end
				end
				H_LEAD, H_LOW: begin
					if (ph_done) begin
						st_ff <= H_HIGH;
						sck_ff <= 1'b1;
					end
				end
				H_HIGH: begin
					if (ph_done) begin
						sck_ff <= 1'b0;
						rx_ff <= {rx_ff[6:0], s_miso};
						tx_ff <= {tx_ff[6:0], 1'b0};
						mosi_ff <= tx_ff[6];
						bit_ff <= bit_ff + 4'h1;
						st_ff <= (bit_ff == FRAME_BITS - 4'h1) ?
							H_TAIL : H_LOW;
					end
				end
				H_TAIL: begin
					if (ph_done) begin
						cs_n_ff <= 1'b1;
						st_ff <= H_GAP;
						ph_ff <= FRAME_GAP_CYC - 4'h1;
					end
				end
				H_GAP: begin
					if (ph_done)
						st_ff <= H_IDLE;
				end
				default: st_ff <= H_IDLE;
			endcase
		end
	end

	assign link.spi_sck = sck_ff;
	assign link.spi_cs_n = cs_n_ff;
	assign link.spi_mosi = mosi_ff;
endmodule // sbc_host
`default_nettype wire

//--- testbench/sbc_mode_wake_sequencer_checker.sv
// Purpose: Concurrent checks on the link pins and the mode outputs.
// Assumes: One pclk domain; presetn is asynchronous and active low.
// Notes: Mode timers allow a few cycles of input synchroniser lag.
`default_nettype none
module sbc_mode_wake_sequencer_checker #(
	parameter int unsigned NREQ = 2000,
	parameter int unsigned HOLD = 300
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic spi_cs_n,
	input wire logic int_n,
	input wire logic rst_n,
	input wire logic watchdog_fault_out,
	input wire logic [2:0] mode_out,
	input wire logic aux_regulator_on,
	input wire logic high_side_switch_on
);
	timeunit 1ns;
	timeprecision 1ns;
	import sbc_pkg::*;
	// ==========================================================
	// Helper counters
	logic [31:0] low_ff;
	logic [31:0] stay_ff;
	logic [2:0] mode_ff;
	// Low time of int_n and time spent in the present mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_ff <= 32'h0;
			stay_ff <= 32'h0;
			mode_ff <= 3'h0;
		end else begin
			low_ff <= int_n ? 32'h0 : low_ff + 32'h1;
			stay_ff <= (mode_out != mode_ff) ? 32'h0 : stay_ff + 32'h1;
			mode_ff <= mode_out;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_pulse_len: assert property ($rose(int_n) |->
		low_ff == INT_PULSE_CYC) else $error("wake pulse length wrong");
	chk_mode_first: assert property ($fell(int_n) |->
		mode_out == M_NREQ && $past(mode_out) == M_NREQ)
		else $error("pulse before request mode");
	chk_hold_time: assert property (mode_ff == M_RESET &&
		mode_out == M_NREQ |-> stay_ff + 32'd2 >= HOLD && stay_ff <= HOLD + 4)
		else $error("reset hold time wrong");
	chk_req_timeout: assert property (mode_ff == M_NREQ &&
		(mode_out == M_RESET || mode_out == M_SLEEP) |->
		stay_ff + 32'd2 >= NREQ && stay_ff <= NREQ + 4)
		else $error("request timeout wrong");
	chk_req_pins: assert property (mode_out == M_NREQ &&
		mode_ff == M_NREQ |-> rst_n && !aux_regulator_on &&
		!high_side_switch_on) else $error("request mode outputs wrong");
	chk_aux_normal: assert property (aux_regulator_on |->
		mode_out == M_NORMAL || mode_ff == M_NORMAL)
		else $error("aux regulator on outside normal");
	chk_sleep_pins: assert property (mode_out == M_SLEEP &&
		mode_ff == M_SLEEP |-> !rst_n && int_n)
		else $error("sleep pins wrong");
	chk_reset_pin: assert property (mode_out == M_RESET &&
		mode_ff == M_RESET |-> !rst_n) else $error("reset pin high");
	chk_fault_reset: assert property ($rose(watchdog_fault_out) |->
		mode_out == M_RESET || mode_ff == M_RESET)
		else $error("fault without reset mode");
	chk_stop_at_cs: assert property (mode_out == M_STOP &&
		mode_ff != M_STOP |-> spi_cs_n && !$past(spi_cs_n, 8))
		else $error("stop entered away from frame end");
endmodule // sbc_mode_wake_sequencer_checker
`default_nettype wire

//--- testbench/sbc_mode_wake_sequencer_tb.sv
// Purpose: Drives the host over APB and judges the mode sequencer.
// Assumes: Shortened counts; both ends share one pclk.
// Notes: Each scenario task checks its own outcome.
`default_nettype none
module sbc_mode_wake_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sbc_pkg::*;
	// ==========================================================
	// Short counts and signals
	localparam int unsigned NREQ = 2000;
	localparam int unsigned HOLD = 300;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic er;
	logic can_wake_evt = 1'b0;
	logic [3:0] wake_inputs = 4'h0;
	logic idd_over = 1'b0;
	logic vdd_low = 1'b0;
	logic forced_wake = 1'b0;
	logic aux_regulator_on;
	logic high_side_switch_on;
	logic [2:0] mode_out;
	logic [2:0] md;
	int num_errors = 0;
	int n_tests = 0;
	sbc_link_if link ();
	// Clock of 100 ns period.
	always #50 pclk = ~pclk;
	// ==========================================================
	// Both ends and the checker
	sbc_dev #(.NREQ_TIMEOUT_CYC(NREQ), .RESET_HOLD_CYC(HOLD),
		.WD_UNIT_CYC(1500)) i_sbc_dev (.pclk(pclk), .presetn(presetn),
		.link(link), .can_wake_evt(can_wake_evt), .wake_inputs(wake_inputs),
		.idd_over(idd_over), .vdd_low(vdd_low), .forced_wake(forced_wake),
		.aux_regulator_on(aux_regulator_on), .mode_out(mode_out),
		.high_side_switch_on(high_side_switch_on));
	sbc_host i_sbc_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	sbc_mode_wake_sequencer_checker #(.NREQ(NREQ), .HOLD(HOLD)) i_chk (
		.pclk(pclk), .presetn(presetn), .spi_cs_n(link.spi_cs_n),
		.int_n(link.int_n), .rst_n(link.rst_n), .mode_out(mode_out),
		.watchdog_fault_out(link.watchdog_fault_out),
		.aux_regulator_on(aux_regulator_on),
		.high_side_switch_on(high_side_switch_on));
	// ==========================================================
	// Shared tasks
	task summarize();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task bad(input string m);
		num_errors++;
		$display("BAD %0t %s", $time, m);
	endtask
	task ck(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			bad(m);
		end
	endtask
	// One APB transfer; the request stands until pready is seen high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		if (k >= 40) begin
			bad("apb hang");
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Sends one byte and polls busy; md keeps the mode seen mid-frame.
	task frame(input logic [7:0] b);
		int k;
		apb(1'b1, REG_CMD, {24'h0, b});
		k = 0;
		do begin
			if (link.spi_cs_n === 1'b0) begin
				md = mode_out;
			end
			apb(1'b0, REG_STAT, 32'h0);
			k++;
		end while (rd[STAT_BUSY] !== 1'b0 && k < 100);
		if (k >= 100) begin
			bad("frame hang");
			summarize();
		end
	endtask
	task wmode(input logic [2:0] m, input int n);
		int k;
		k = 0;
		while (mode_out !== m && k < n) begin
			@(posedge pclk);
			k++;
		end
		n_tests++;
		if (mode_out !== m) begin
			bad("mode not reached");
			summarize();
		end
	endtask
	task wint(input logic v, input int n);
		int k;
		k = 0;
		while (link.int_n !== v && k < n) begin
			@(posedge pclk);
			k++;
		end
		if (link.int_n !== v) begin
			bad("interrupt wait");
			summarize();
		end
	endtask
	task wake_seen();
		wint(1'b0, 300);
		ck(mode_out === M_NREQ, "mode at pulse");
		wint(1'b1, 150);
		repeat (FIRST_SPI_CYC + 32'd20) @(posedge pclk);
	endtask
	task go_stop(input logic [7:0] t, input logic [7:0] m);
		frame(t);
		frame(8'h21);
		frame(m);
		ck(md === M_NORMAL, "stop before frame end");
		wmode(M_STOP, 10);
	endtask
	// ==========================================================
	// Scenarios
	task s_cycle();
		wmode(M_NREQ, HOLD + 20);
		wmode(M_RESET, NREQ + 20);
		wmode(M_NREQ, HOLD + 20);
	endtask
	task s_normal();
		apb(1'b0, 12'hFFC, 32'h0);
		ck(er === 1'b1 && rd === 32'h0, "unmapped read");
		frame(8'h13);
		frame(8'h21);
		wmode(M_NORMAL, 20);
		repeat (2) @(posedge pclk);
		ck(aux_regulator_on === 1'b1, "aux off in normal");
		frame(8'h31);
		frame(8'h00);
		apb(1'b0, REG_RX, 32'h0);
		ck(rd[7:0] === 8'h02 && high_side_switch_on === 1'b1, "status");
		// Low supply in normal mode forces reset, then request mode again.
		vdd_low <= 1'b1;
		wmode(M_RESET, 10);
		vdd_low <= 1'b0;
		ck(link.rst_n === 1'b0, "low supply");
		wmode(M_NREQ, HOLD + 20);
	endtask
	task s_cs_wake();
		go_stop(8'h13, 8'h23);
		repeat (100) @(posedge pclk);
		ck(mode_out === M_STOP && link.int_n === 1'b1, "left stop");
		// A bare command write: polling busy would outlast the wake pulse.
		apb(1'b1, REG_CMD, 32'h0);
		wake_seen();
		apb(1'b0, REG_STAT, 32'h0);
		ck(rd[STAT_INT] === 1'b1, "pulse not seen");
		frame(8'h13);
		frame(8'h21);
		wmode(M_NORMAL, 20);
	endtask
	// Device-side wakes: CAN, input change, over-current, forced wake.
	task s_dev_wake();
		logic [7:0] exp [4] = '{8'h81, 8'h21, 8'h01, 8'h01};
		for (int i = 0; i < 4; i++) begin
			go_stop(8'h13, 8'h23);
			idd_over <= (i == 2);
			repeat (DEGLITCH_CYC - 32'd60) @(posedge pclk);
			ck(mode_out === M_STOP, "early wake");
			can_wake_evt <= (i == 0);
			forced_wake <= (i == 3);
			if (i == 1) begin
				wake_inputs <= 4'h4;
			end
			wake_seen();
			idd_over <= 1'b0;
			can_wake_evt <= 1'b0;
			forced_wake <= 1'b0;
			frame(8'h00);
			apb(1'b0, REG_RX, 32'h0);
			ck(rd[7:0] === exp[i], "wake flags");
			frame(8'h40);
		end
	endtask
	task s_stop_wd();
		go_stop(8'h10, 8'h2B);
		wmode(M_RESET, 1600);
		repeat (2) @(posedge pclk);
		ck(link.rst_n === 1'b0 && link.watchdog_fault_out === 1'b1, "wd");
		wmode(M_NREQ, HOLD + 20);
		frame(8'h13);
		ck(link.watchdog_fault_out === 1'b0, "fault stuck");
	endtask
	task s_sleep();
		frame(8'h21);
		frame(8'h24);
		wmode(M_SLEEP, 10);
		repeat (3) @(posedge pclk);
		ck(link.rst_n === 1'b0 && link.int_n === 1'b1, "sleep pins");
		can_wake_evt <= 1'b1;
		wmode(M_RESET, 20);
		can_wake_evt <= 1'b0;
		wmode(M_NREQ, HOLD + 20);
		wmode(M_SLEEP, NREQ + 20);
	endtask
	// Main sequence: reset, then every scenario in turn.
	initial begin
		repeat (20) @(posedge pclk);
		ck(mode_out === M_RESET && link.rst_n === 1'b0, "reset");
		presetn <= 1'b1;
		s_cycle();
		s_normal();
		s_cs_wake();
		s_dev_wake();
		s_stop_wd();
		s_sleep();
		summarize();
	end
endmodule // sbc_mode_wake_sequencer_tb
`default_nettype wire
